// *** logic/acss_defs.svh ***
// Register offsets, field positions, reset values and timing counts of the audio clock source block.
`ifndef ACSS_DEFS_SVH
`define ACSS_DEFS_SVH
`define ACSS_ADDR_W 8
`define ACSS_OFF_CTRL 8'h00
`define ACSS_OFF_HOST_PER 8'h04
`define ACSS_OFF_STATUS 8'h08
`define ACSS_OFF_INT_STAT 8'h0C
`define ACSS_OFF_INT_MASK 8'h10
`define ACSS_OFF_PER_WORD 8'h14
`define ACSS_OFF_PER_OPT 8'h18
`define ACSS_OFF_PER_COAX 8'h1C
`define ACSS_CTRL_MASTER 0
`define ACSS_CTRL_PREF_LO 1
`define ACSS_CTRL_SPEED_LO 3
`define ACSS_CTRL_RESET 5'h00
`define ACSS_HOST_PER_RESET 16'h0008
`define ACSS_ST_REF_LO 6
`define ACSS_ST_RATE_ERR 8
`define ACSS_ST_CHAN_LO 9
`define ACSS_INT_REF_CHG 0
`define ACSS_INT_FALLBACK 1
`define ACSS_INT_RATE_ERR 2
`define ACSS_PER_W 16
`define ACSS_PER_MIN 4
`define ACSS_PER_MAX 1024
`define ACSS_QUAL_EDGES 8
`define ACSS_PER_TOL 1
`define ACSS_INT_HALF 4
`define ACSS_CHAN_SINGLE 4'h8
`define ACSS_CHAN_DOUBLE 4'h4
`define ACSS_CHAN_QUAD 4'h2
`define ACSS_RESP_OKAY 2'h0
`define ACSS_RESP_SLVERR 2'h2
`endif

// *** logic/acss_pkg.sv ***
// Types shared by the audio clock source block.
package acss_pkg;
	// Reference that clocks the device; the same code selects the preferred input.
	typedef enum logic [1:0] {
		ACSS_REF_INT = 2'b00,
		ACSS_REF_OPT = 2'b01,
		ACSS_REF_COAX = 2'b10,
		ACSS_REF_WORD = 2'b11
	} acss_ref_t;
	// Per-input status as software reads it.
	typedef enum logic [1:0] {
		ACSS_ST_NOLOCK = 2'b00,
		ACSS_ST_LOCK = 2'b01,
		ACSS_ST_SYNC = 2'b10
	} acss_status_t;
	// Sample rate range chosen by the host.
	typedef enum logic [1:0] {
		ACSS_SPD_SINGLE = 2'b00,
		ACSS_SPD_DOUBLE = 2'b01,
		ACSS_SPD_QUAD = 2'b10
	} acss_speed_t;
	// Switch-over sequencer states.
	typedef enum logic [0:0] {
		ACSS_SW_RUN = 1'b0,
		ACSS_SW_WAIT = 1'b1
	} acss_sw_state_t;
endpackage : acss_pkg

// *** logic/acss_rate_meter.sv ***
// Period meter and lock qualifier for one incoming recovered clock.
`timescale 1ns/1ps
`default_nettype none
`include "acss_defs.svh"
module acss_rate_meter #(
	parameter int PER_W = `ACSS_PER_W,
	parameter int PER_MIN = `ACSS_PER_MIN,
	parameter int PER_MAX = `ACSS_PER_MAX,
	parameter int QUAL_EDGES = `ACSS_QUAL_EDGES,
	parameter int PER_TOL = `ACSS_PER_TOL
) (
	// Clock and reset.
	input wire logic sys_clk,
	input wire logic nrst,
	// Recovered clock pin.
	input wire logic clk_pin,
	// Measurement results.
	output logic locked,
	output logic [PER_W-1:0] period,
	output logic level
);
	logic sync1_reg;
	logic sync2_reg;
	logic last_reg;
	logic [PER_W-1:0] cnt_reg;
	logic [7:0] qual_reg;
	logic edge_seen;
	logic in_tol;
	logic in_range;

	if (PER_MAX >= (1 << PER_W) || PER_MIN < 2 || QUAL_EDGES < 2 || QUAL_EDGES > 255) begin : g_bad_param
		$error("acss_rate_meter: parameter out of range");
	end

	// Two flip-flops bring the pin into the sys_clk domain; only the second is looked at.
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			sync1_reg <= 1'b0;
			sync2_reg <= 1'b0;
			last_reg <= 1'b0;
		end else begin
			sync1_reg <= clk_pin;
			sync2_reg <= sync1_reg;
			last_reg <= sync2_reg;
		end
	end

	assign edge_seen = sync2_reg & ~last_reg;
	assign level = sync2_reg;
	assign in_range = (cnt_reg >= PER_W'(PER_MIN)) && (cnt_reg <= PER_W'(PER_MAX));
	assign in_tol = (cnt_reg >= period) ? ((cnt_reg - period) <= PER_W'(PER_TOL))
		: ((period - cnt_reg) <= PER_W'(PER_TOL));

	// Counts cycles between rising edges; a missing edge ends the lock once the count passes PER_MAX.
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			cnt_reg <= '0;
			period <= '0;
		end else if (edge_seen) begin
			cnt_reg <= PER_W'(1);
			period <= cnt_reg;
		end else if (cnt_reg <= PER_W'(PER_MAX)) begin
			cnt_reg <= cnt_reg + PER_W'(1);
		end
	end

	// Lock needs QUAL_EDGES consecutive periods in range and within tolerance of each other.
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			qual_reg <= 8'h00;
			locked <= 1'b0;
		end else if (cnt_reg > PER_W'(PER_MAX)) begin
			qual_reg <= 8'h00; // see RULE_13
			locked <= 1'b0;
		end else if (edge_seen) begin
			if (in_range && in_tol) begin
				if (qual_reg < 8'(QUAL_EDGES)) begin
					qual_reg <= qual_reg + 8'h01;
				end
				locked <= (qual_reg >= 8'(QUAL_EDGES - 1)); // see RULE_13
			end else begin
				qual_reg <= 8'h00;
				locked <= 1'b0;
			end
		end
	end
endmodule : acss_rate_meter
`default_nettype wire

// *** logic/acss_top.sv ***
// Clock source selection, lock and sync status with an AXI4-Lite register file.
// Behaviour
// RULE_01: An input with no recognised rate reports no-lock and a zero period.
// RULE_02: Automatic mode watches all inputs and leaves internal clock once one is valid.
// RULE_03: Automatic mode returns to internal clock as master when the reference is lost.
// RULE_04: Master mode runs only from internal reference, ignoring all inputs.
// RULE_05: Inputs are measured together; the preferred input clocks while it is valid.
// RULE_06: Word, optical and coaxial inputs each report no lock, lock or sync.
// RULE_07: The current reference (internal, optical, coaxial, word) is readable.
// RULE_08: Sync is withheld when an input period differs from the running period.
// RULE_09: A synced external reference off the host rate raises an error flag.
// RULE_10: Double speed selects two-way optical multiplexing, four optical channels.
// RULE_11: Quad speed selects four-way optical multiplexing, two optical channels.
// RULE_12: In master mode every other connected device must be a clock slave.
// RULE_13: Switching makes no runt pulses; validity needs a qualification period.
`timescale 1ns/1ps
`default_nettype none
`include "acss_defs.svh"
module acss_top
	import acss_pkg::*;
#(
	parameter int PER_W = `ACSS_PER_W,
	parameter int INT_HALF = `ACSS_INT_HALF
) (
	// Clock and reset.
	input wire logic sys_clk,
	input wire logic nrst,
	// AXI4-Lite write address and data.
	input wire logic [`ACSS_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response.
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read.
	input wire logic [`ACSS_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Recovered clocks from the word clock, optical and coaxial receivers.
	input wire logic word_clk_in,
	input wire logic opt_clk_in,
	input wire logic coax_clk_in,
	// Clock, mode and interrupt outputs.
	output logic ref_clk_out,
	output logic clock_master,
	output logic double_rate_multiplex,
	output logic quad_rate_multiplex,
	output logic irq
);
	localparam int NIN = 3;
	logic [NIN-1:0] lock_w;
	logic [NIN-1:0] lvl_w;
	logic [PER_W-1:0] per_w [NIN];
	logic [NIN-1:0] pin_w;
	logic [4:0] ctrl_reg;
	logic [PER_W-1:0] host_per_reg;
	logic [2:0] int_stat_reg;
	logic [2:0] int_mask_reg;
	logic aw_full_reg;
	logic w_full_reg;
	logic [`ACSS_ADDR_W-1:0] aw_addr_reg;
	logic [31:0] w_data_reg;
	logic [3:0] w_strb_reg;
	logic aw_full_next;
	logic w_full_next;
	logic do_write;
	logic ar_take;
	acss_ref_t cur_ref_reg;
	acss_ref_t want_ref;
	acss_sw_state_t sw_state_reg;
	logic [7:0] div_reg;
	logic int_lvl_reg;
	logic tgt_lvl;
	logic cur_lvl;
	logic park_reg, sw_go;
	logic [NIN:0] lvl_prev_reg;
	logic [PER_W-1:0] run_per;
	logic rate_err_reg;
	logic rate_err_next;
	logic [2:0] ev;
	logic [2:0] ev_dly_reg;
	acss_status_t st_w [NIN];

	if (INT_HALF < 1 || INT_HALF > 255) begin : g_bad_param
		$error("acss_top: INT_HALF out of range");
	end
	// Index of a reference code among the three meters (word 0, optical 1, coaxial 2).
	function automatic int ref_idx(input acss_ref_t r);
		case (r)
			ACSS_REF_WORD: ref_idx = 0;
			ACSS_REF_OPT: ref_idx = 1;
			ACSS_REF_COAX: ref_idx = 2;
			default: ref_idx = 0;
		endcase
	endfunction : ref_idx
	// True when two periods agree within tolerance.
	function automatic logic per_match(input logic [PER_W-1:0] a, input logic [PER_W-1:0] b);
		per_match = (a >= b) ? ((a - b) <= PER_W'(`ACSS_PER_TOL)) : ((b - a) <= PER_W'(`ACSS_PER_TOL));
	endfunction : per_match
	assign pin_w = {coax_clk_in, opt_clk_in, word_clk_in};
	// One meter per input; all inputs are measured at the same time.
	for (genvar i = 0; i < NIN; i++) begin : g_meter
		acss_rate_meter #(.PER_W(PER_W)) u_meter (
			.sys_clk(sys_clk),
			.nrst(nrst),
			.clk_pin(pin_w[i]), // see RULE_05
			.locked(lock_w[i]),
			.period(per_w[i]),
			.level(lvl_w[i])
		);
		// Status of one input against the running period.
		always_comb begin
			if (!lock_w[i]) begin
				st_w[i] = ACSS_ST_NOLOCK; // see RULE_01
			end else if (per_match(per_w[i], run_per)) begin
				st_w[i] = ACSS_ST_SYNC; // see RULE_06
			end else begin
				st_w[i] = ACSS_ST_LOCK; // see RULE_08
			end
		end
	end

	// Period the device runs at: that of the current reference, or of the internal divider.
	assign run_per = (cur_ref_reg == ACSS_REF_INT) ? PER_W'(2 * INT_HALF) : per_w[ref_idx(cur_ref_reg)];

	// Source choice: master mode forces internal, otherwise preferred first, then any valid.
	always_comb begin
		want_ref = ACSS_REF_INT; // see RULE_03
		if (ctrl_reg[`ACSS_CTRL_MASTER]) begin
			want_ref = ACSS_REF_INT; // see RULE_04
		end else if (acss_ref_t'(ctrl_reg[`ACSS_CTRL_PREF_LO +: 2]) != ACSS_REF_INT
			&& lock_w[ref_idx(acss_ref_t'(ctrl_reg[`ACSS_CTRL_PREF_LO +: 2]))]) begin
			want_ref = acss_ref_t'(ctrl_reg[`ACSS_CTRL_PREF_LO +: 2]); // see RULE_05
		end else if (lock_w[0]) begin
			want_ref = ACSS_REF_WORD; // see RULE_02
		end else if (lock_w[1]) begin
			want_ref = ACSS_REF_OPT;
		end else if (lock_w[2]) begin
			want_ref = ACSS_REF_COAX;
		end
	end

	// Internal reference divider.
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			div_reg <= 8'h00;
			int_lvl_reg <= 1'b0;
		end else if (div_reg >= 8'(INT_HALF - 1)) begin
			div_reg <= 8'h00;
			int_lvl_reg <= ~int_lvl_reg;
		end else begin
			div_reg <= div_reg + 8'h01;
		end
	end

	assign tgt_lvl = (want_ref == ACSS_REF_INT) ? int_lvl_reg : lvl_w[ref_idx(want_ref)];
	assign cur_lvl = (cur_ref_reg == ACSS_REF_INT) ? int_lvl_reg : lvl_w[ref_idx(cur_ref_reg)];
	assign sw_go = (sw_state_reg == ACSS_SW_WAIT) && (want_ref != cur_ref_reg) && park_reg && !tgt_lvl
		&& lvl_prev_reg[(want_ref == ACSS_REF_INT) ? 0 : ref_idx(want_ref) + 1];

	// Switch-over parks the output low once the old source is low or lost, then joins the new one as it falls.
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			sw_state_reg <= ACSS_SW_RUN;
			cur_ref_reg <= ACSS_REF_INT;
			park_reg <= 1'b0;
			lvl_prev_reg <= '0;
		end else begin
			lvl_prev_reg <= {lvl_w, int_lvl_reg};
			park_reg <= (sw_state_reg == ACSS_SW_WAIT) && (park_reg || !cur_lvl
				|| (cur_ref_reg != ACSS_REF_INT && !lock_w[ref_idx(cur_ref_reg)])); // see RULE_03
			case (sw_state_reg)
				ACSS_SW_RUN: begin
					if (want_ref != cur_ref_reg) begin
						sw_state_reg <= ACSS_SW_WAIT;
					end
				end
				ACSS_SW_WAIT: begin
					if (want_ref == cur_ref_reg && !cur_lvl) begin
						sw_state_reg <= ACSS_SW_RUN;
					end else if (sw_go) begin
						cur_ref_reg <= want_ref; // see RULE_13
						sw_state_reg <= ACSS_SW_RUN;
					end
				end
				default: sw_state_reg <= ACSS_SW_RUN;
			endcase
		end
	end

	// Clock, master and multiplex outputs.
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			ref_clk_out <= 1'b0;
			clock_master <= 1'b1;
			double_rate_multiplex <= 1'b0;
			quad_rate_multiplex <= 1'b0;
		end else begin
			ref_clk_out <= park_reg ? 1'b0 : cur_lvl; // see RULE_13
			clock_master <= (cur_ref_reg == ACSS_REF_INT); // see RULE_03
			double_rate_multiplex <= (ctrl_reg[`ACSS_CTRL_SPEED_LO +: 2] == ACSS_SPD_DOUBLE); // see RULE_10
			quad_rate_multiplex <= (ctrl_reg[`ACSS_CTRL_SPEED_LO +: 2] == ACSS_SPD_QUAD); // see RULE_11
		end
	end

	// Error when the synced external reference runs off the host's requested period.
	assign rate_err_next = (cur_ref_reg != ACSS_REF_INT) && lock_w[ref_idx(cur_ref_reg)]
		&& !per_match(run_per, host_per_reg); // see RULE_09

	// Events: reference change, loss of the current reference, rising rate error.
	assign ev[`ACSS_INT_REF_CHG] = sw_go;
	assign ev[`ACSS_INT_FALLBACK] = (cur_ref_reg != ACSS_REF_INT) && !lock_w[ref_idx(cur_ref_reg)] && !ev_dly_reg[1];
	assign ev[`ACSS_INT_RATE_ERR] = rate_err_next && !rate_err_reg;

	// Event history and rate error flag.
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			rate_err_reg <= 1'b0;
			ev_dly_reg <= 3'h0;
		end else begin
			rate_err_reg <= rate_err_next;
			ev_dly_reg <= {1'b0, (cur_ref_reg != ACSS_REF_INT) && !lock_w[ref_idx(cur_ref_reg)], 1'b0};
		end
	end

	// Sticky interrupt status; a read clears it, a new event in the same cycle wins.
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			int_stat_reg <= 3'h0;
			irq <= 1'b0;
		end else begin
			if (ar_take && s_axi_araddr == `ACSS_OFF_INT_STAT) begin
				int_stat_reg <= ev;
			end else begin
				int_stat_reg <= int_stat_reg | ev;
			end
			irq <= |(int_stat_reg & int_mask_reg);
		end
	end

	// Write channel acceptance in either order.
	assign do_write = aw_full_reg && w_full_reg && !s_axi_bvalid;
	assign aw_full_next = (aw_full_reg && !do_write) || (s_axi_awvalid && s_axi_awready);
	assign w_full_next = (w_full_reg && !do_write) || (s_axi_wvalid && s_axi_wready);
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			aw_full_reg <= 1'b0;
			w_full_reg <= 1'b0;
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			aw_addr_reg <= '0;
			w_data_reg <= 32'h00000000;
			w_strb_reg <= 4'h0;
		end else begin
			aw_full_reg <= aw_full_next;
			w_full_reg <= w_full_next;
			s_axi_awready <= !aw_full_next;
			s_axi_wready <= !w_full_next;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_addr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end
		end
	end

	// Register writes and the write response.
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			ctrl_reg <= `ACSS_CTRL_RESET;
			host_per_reg <= `ACSS_HOST_PER_RESET;
			int_mask_reg <= 3'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `ACSS_RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= `ACSS_RESP_OKAY;
			case (aw_addr_reg)
				`ACSS_OFF_CTRL: if (w_strb_reg[0]) ctrl_reg <= w_data_reg[4:0];
				`ACSS_OFF_HOST_PER: begin
					if (w_strb_reg[0]) host_per_reg[7:0] <= w_data_reg[7:0];
					if (w_strb_reg[1]) host_per_reg[15:8] <= w_data_reg[15:8];
				end
				`ACSS_OFF_INT_MASK: if (w_strb_reg[0]) int_mask_reg <= w_data_reg[2:0];
				`ACSS_OFF_STATUS, `ACSS_OFF_INT_STAT, `ACSS_OFF_PER_WORD, `ACSS_OFF_PER_OPT,
				`ACSS_OFF_PER_COAX: s_axi_bresp <= `ACSS_RESP_OKAY;
				default: s_axi_bresp <= `ACSS_RESP_SLVERR;
			endcase
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Read channel: one read at a time, data one cycle after the address is taken.
	assign ar_take = s_axi_arvalid && s_axi_arready;
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `ACSS_RESP_OKAY;
		end else if (ar_take) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= `ACSS_RESP_OKAY;
			s_axi_rdata <= 32'h00000000;
			case (s_axi_araddr)
				`ACSS_OFF_CTRL: s_axi_rdata[4:0] <= ctrl_reg;
				`ACSS_OFF_HOST_PER: s_axi_rdata[PER_W-1:0] <= host_per_reg;
				`ACSS_OFF_STATUS: s_axi_rdata[12:0] <= {(ctrl_reg[`ACSS_CTRL_SPEED_LO +: 2] == ACSS_SPD_QUAD)
					? `ACSS_CHAN_QUAD : (ctrl_reg[`ACSS_CTRL_SPEED_LO +: 2] == ACSS_SPD_DOUBLE)
					? `ACSS_CHAN_DOUBLE : `ACSS_CHAN_SINGLE, rate_err_reg, cur_ref_reg,
					st_w[2], st_w[1], st_w[0]}; // see RULE_07
				`ACSS_OFF_INT_STAT: s_axi_rdata[2:0] <= int_stat_reg;
				`ACSS_OFF_INT_MASK: s_axi_rdata[2:0] <= int_mask_reg;
				`ACSS_OFF_PER_WORD: s_axi_rdata[PER_W-1:0] <= lock_w[0] ? per_w[0] : '0; // see RULE_01
				`ACSS_OFF_PER_OPT: s_axi_rdata[PER_W-1:0] <= lock_w[1] ? per_w[1] : '0;
				`ACSS_OFF_PER_COAX: s_axi_rdata[PER_W-1:0] <= lock_w[2] ? per_w[2] : '0;
				default: s_axi_rresp <= `ACSS_RESP_SLVERR;
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end
endmodule : acss_top
`default_nettype wire

// *** bench/acss_checker.sv ***
// Port-level assertions for the audio clock source block.
`timescale 1ns/1ps
`default_nettype none
module acss_checker #(
	parameter int INT_HALF = 4
) (
	// Clock and reset.
	input wire logic sys_clk,
	input wire logic nrst,
	// Bus handshakes.
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Clock and mode outputs.
	input wire logic ref_clk_out,
	input wire logic clock_master,
	input wire logic double_rate_multiplex,
	input wire logic quad_rate_multiplex
);
	logic [15:0] hi_cnt_reg;
	// Counts how many cycles the reference output has been high.
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			hi_cnt_reg <= 16'h0000;
		end else begin
			hi_cnt_reg <= ref_clk_out ? hi_cnt_reg + 16'h0001 : 16'h0000;
		end
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	property p_speed_excl;
		!(double_rate_multiplex && quad_rate_multiplex);
	endproperty
	a_speed_excl: assert property (p_speed_excl) else $error("both multiplex modes on");
	property p_int_half;
		clock_master && $fell(ref_clk_out) |-> hi_cnt_reg == 16'(INT_HALF);
	endproperty
	a_int_half: assert property (p_int_half) else $error("internal high phase wrong");
	property p_no_runt_hi;
		$rose(ref_clk_out) |=> ref_clk_out;
	endproperty
	a_no_runt_hi: assert property (p_no_runt_hi) else $error("short high pulse");
	property p_no_runt_lo;
		$fell(ref_clk_out) |=> !ref_clk_out;
	endproperty
	a_no_runt_lo: assert property (p_no_runt_lo) else $error("short low pulse");
	property p_wr_take;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> !s_axi_awready ##[0:1] s_axi_bvalid;
	endproperty
	a_wr_take: assert property (p_wr_take) else $error("write not answered");
	property p_b_hold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("write response dropped");
	property p_rd_take;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
	endproperty
	a_rd_take: assert property (p_rd_take) else $error("read not answered");
	property p_r_hold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_r_hold: assert property (p_r_hold) else $error("read data dropped");
endmodule : acss_checker
bind acss_top acss_checker #(.INT_HALF(INT_HALF)) i_chk (.*);
`default_nettype wire

// *** bench/acss_src_model.sv ***
// Behavioural external digital sources feeding recovered clocks to the block.
`timescale 1ns/1ps
`default_nettype none
module acss_src_model (
	// Source enables: bit 0 word, bit 1 optical, bit 2 coaxial.
	input wire logic [2:0] src_en,
	// Half periods of each source in ns.
	input wire logic [15:0] word_half,
	input wire logic [15:0] opt_half,
	input wire logic [15:0] coax_half,
	// Recovered clocks toward the block.
	output logic word_clk_in,
	output logic opt_clk_in,
	output logic coax_clk_in
);
	// Each source runs as its own master, with the block as slave; a disabled one rests low.
	initial begin
		word_clk_in = 1'b0;
		#7;
		forever begin
			word_clk_in = src_en[0];
			#(word_half);
			word_clk_in = 1'b0;
			#(word_half);
		end
	end
	// Optical source, offset so its edges never meet the system clock edges.
	initial begin
		opt_clk_in = 1'b0;
		#13;
		forever begin
			opt_clk_in = src_en[1];
			#(opt_half);
			opt_clk_in = 1'b0;
			#(opt_half);
		end
	end
	// Coaxial source.
	initial begin
		coax_clk_in = 1'b0;
		#29;
		forever begin
			coax_clk_in = src_en[2];
			#(coax_half);
			coax_clk_in = 1'b0;
			#(coax_half);
		end
	end
endmodule : acss_src_model
`default_nettype wire

// *** bench/tb.sv ***
// Register-level testbench for the audio clock source block.
`timescale 1ns/1ps
`default_nettype none
`include "acss_defs.svh"
module tb;
	logic sys_clk, nrst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, word_clk_in, opt_clk_in, coax_clk_in;
	logic ref_clk_out, clock_master, double_rate_multiplex, quad_rate_multiplex, irq;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, rs;
	logic [2:0] src_en;
	logic [15:0] word_half, opt_half, coax_half;
	int bad_count, checks_done, cyc;
	acss_top i_dut (.*);
	acss_src_model i_src (.*);
	// System clock at 25 MHz.
	always #20 sys_clk = ~sys_clk;
	// Compares a seen value with the expected one.
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		checks_done++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD %0t %s: saw %h expected %h", $time, msg, seen, exp);
		end
	endtask : chk
	// Prints the counts and the verdict, then ends the run.
	task automatic stop_test();
		$display("checks %0d, mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : stop_test
	// One register write; both channels offered together.
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge sys_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		chk(32'(s_axi_bresp), 32'(er), "write response");
	endtask : wr
	// One register read.
	task automatic rd_reg(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge sys_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : rd_reg
	// Reads a register and compares data and response.
	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		rd_reg(a, rd, rs);
		chk(rd, exp, "read data");
		chk(32'(rs), 32'h0, "read response");
	endtask : rchk
	// Polls the status register until the masked field reaches a value.
	task automatic wait_st(input logic [31:0] m, input logic [31:0] v);
		int n;
		n = 0;
		do begin
			rd_reg(`ACSS_OFF_STATUS, rd, rs);
			n++;
		end while ((rd & m) !== v && n < 1500);
		chk(rd & m, v, "status field");
	endtask : wait_st
	// Cuts a hung run short.
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			bad_count++;
			stop_test();
		end
	end
	// Main sequence.
	initial begin
		{sys_clk, nrst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 7'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, src_en} = 51'h0;
		s_axi_wstrb = 4'hF;
		{word_half, opt_half, coax_half} = {16'h00A0, 16'h00A0, 16'h00A0};
		{bad_count, checks_done, cyc} = {32'h0, 32'h0, 32'h0};
		repeat (2) @(posedge sys_clk);
		nrst <= 1'b1;
		@(negedge sys_clk);
		chk(32'(clock_master), 32'h1, "master after reset");
		rchk(`ACSS_OFF_CTRL, 32'h0);
		rchk(`ACSS_OFF_HOST_PER, 32'h8);
		rchk(`ACSS_OFF_INT_MASK, 32'h0);
		rchk(`ACSS_OFF_STATUS, 32'h1000);
		rd_reg(8'h40, rd, rs);
		chk({rd[29:0], rs}, 32'h2, "unmapped read");
		wr(8'h40, 32'hFFFFFFFF, 2'h2);
		wr(`ACSS_OFF_STATUS, 32'h0, 2'h0);
		$display("test reset done");
		for (int s = 0; s < 3; s++) begin
			wr(`ACSS_OFF_CTRL, 32'(s) << 3, 2'h0);
			@(negedge sys_clk);
			chk(32'(double_rate_multiplex), 32'(s == 1), "double mux");
			chk(32'(quad_rate_multiplex), 32'(s == 2), "quad mux");
			rd_reg(`ACSS_OFF_STATUS, rd, rs);
			chk(32'(rd[12:9]), (s == 0) ? 32'h8 : (s == 1) ? 32'h4 : 32'h2, "channels");
		end
		wr(`ACSS_OFF_CTRL, 32'h0, 2'h0);
		$display("test speed done");
		src_en <= 3'b010;
		wait_st(32'hC0, 32'h40);
		rchk(`ACSS_OFF_STATUS, 32'h1048);
		@(negedge sys_clk);
		chk(32'(clock_master), 32'h0, "slave on optical");
		chk(32'(irq), 32'h0, "masked irq");
		wr(`ACSS_OFF_INT_MASK, 32'h7, 2'h0);
		repeat (3) @(negedge sys_clk);
		chk(32'(irq), 32'h1, "unmasked irq");
		rchk(`ACSS_OFF_INT_STAT, 32'h1);
		rchk(`ACSS_OFF_INT_STAT, 32'h0);
		@(negedge sys_clk);
		chk(32'(irq), 32'h0, "irq after clear");
		$display("test automatic done");
		src_en <= 3'b110;
		wr(`ACSS_OFF_CTRL, 32'h4, 2'h0);
		wait_st(32'hC0, 32'h80);
		rchk(`ACSS_OFF_STATUS, 32'h10A8);
		rchk(`ACSS_OFF_INT_STAT, 32'h1);
		$display("test preferred done");
		word_half <= 16'h0140;
		src_en <= 3'b111;
		wait_st(32'h3, 32'h1);
		wr(`ACSS_OFF_HOST_PER, 32'h10, 2'h0);
		rchk(`ACSS_OFF_STATUS, 32'h11A9);
		rchk(`ACSS_OFF_INT_STAT, 32'h4);
		wr(`ACSS_OFF_HOST_PER, 32'h8, 2'h0);
		$display("test rate done");
		wr(`ACSS_OFF_CTRL, 32'h1, 2'h0);
		wait_st(32'hC0, 32'h0);
		rchk(`ACSS_OFF_STATUS, 32'h1029);
		@(negedge sys_clk);
		chk(32'(clock_master), 32'h1, "master mode");
		rchk(`ACSS_OFF_INT_STAT, 32'h1);
		$display("test master done");
		src_en <= 3'b100;
		wait_st(32'hF, 32'h0);
		wr(`ACSS_OFF_CTRL, 32'h4, 2'h0);
		wait_st(32'hC0, 32'h80);
		rchk(`ACSS_OFF_INT_STAT, 32'h1);
		src_en <= 3'b000;
		wait_st(32'hC0, 32'h0);
		@(negedge sys_clk);
		chk(32'(clock_master), 32'h1, "fallback master");
		chk(32'(irq), 32'h1, "fallback irq");
		rchk(`ACSS_OFF_INT_STAT, 32'h3);
		rchk(`ACSS_OFF_STATUS, 32'h1000);
		$display("test fallback done");
		stop_test();
	end
endmodule : tb
`default_nettype wire
